// ===== spi_cfg_pkg.sv
// Register map, field positions and pin bundles of the serial interface
package spi_cfg_pkg;
    // Byte addresses of the APB word registers
    localparam logic [7:0] OFF_MAIN     = 8'h00;
    localparam logic [7:0] OFF_OPT      = 8'h04;
    localparam logic [7:0] OFF_BAUD     = 8'h08;
    localparam logic [7:0] OFF_STAT     = 8'h0c;
    localparam logic [7:0] OFF_DATA     = 8'h10;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
    // Main control fields
    localparam int MAIN_RFIE = 7;
    localparam int MAIN_SPE  = 6;
    localparam int MAIN_TIE  = 5;
    localparam int MAIN_ROLE_SELECT = 4;
    localparam int MAIN_CLOCK_POLARITY = 3;
    localparam int MAIN_CLOCK_PHASE = 2;
    localparam int MAIN_SELECT_OUTPUT_ENABLE = 1;
    localparam int MAIN_LSBF = 0;
    // Option control fields
    localparam int OPT_MODE_FAULT_ENABLE = 4;
    localparam int OPT_BIDIR  = 3;
    localparam int OPT_SWAI   = 1;
    localparam int OPT_SINGLE_WIRE_SELECT   = 0;
    localparam logic [7:0] OPT_IMPL  = 8'h1b;
    // Status fields
    localparam int STAT_RXF  = 7;
    localparam int STAT_TXEF = 5;
    localparam int STAT_MODE_FAULT_FLAG = 4;
    // Baud fields
    localparam int BAUD_PRE_LSB = 4;
    localparam logic [7:0] BAUD_IMPL = 8'h77;
    // Interrupt status and mask bits
    localparam int IRQ_RX   = 0;
    localparam int IRQ_MODE_FAULT_FLAG = 1;
    localparam int IRQ_TX   = 2;
    localparam logic [2:0] IRQ_ALL = 3'h7;
    // Reset values
    localparam logic [7:0] MAIN_RST = 8'h04;
    localparam logic [7:0] OPT_RST  = 8'h00;
    localparam logic [7:0] BAUD_RST = 8'h00;
    localparam logic [2:0] MASK_RST = 3'h7;
    // Byte framing
    localparam logic [3:0] LAST_BIT  = 4'h7;
    localparam logic [4:0] LAST_HALF = 5'h10;
    localparam logic [4:0] CPHA1_END = 5'h0f;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic ss_n;
    } pin_in_s;

    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic mosi_o;
        logic mosi_oe;
        logic miso_o;
        logic miso_oe;
        logic ss_n_o;
        logic ss_oe;
    } pin_out_s;

    typedef enum logic [1:0] {ST_IDLE, ST_MASTER, ST_SLAVE} st_e;
endpackage : spi_cfg_pkg

// ===== spi_control_config.sv
// Byte-wide serial interface with APB registers, master and slave roles
module spi_control_config (
    // Clock, reset, enables
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  ce,
    input  wire logic                  wait_mode,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Interrupt
    output logic                       irq,
    // Serial pins
    input  wire spi_cfg_pkg::pin_in_s  pins_in,
    output spi_cfg_pkg::pin_out_s      pins_out
);
    import spi_cfg_pkg::*;

    function automatic logic [10:0] half_period(input logic [7:0] b);
        half_period = (11'(b[BAUD_PRE_LSB +: 3]) + 11'd1) << b[2:0];
    endfunction : half_period

    function automatic logic [7:0] shift_in(input logic [7:0] s,
                                            input logic       d,
                                            input logic       lsbf);
        shift_in = lsbf ? {d, s[7:1]} : {s[6:0], d};
    endfunction : shift_in

    logic [7:0]  main_q, opt_q, baud_q, txbuf_q, rxbuf_q, tsh_q, rsh_q;
    logic [2:0]  irq_st_q, irq_mask_q;
    logic        rxf_q, txef_q, mode_fault_flag_q, txfull_q;
    logic        rxf_arm_q, txef_arm_q, mode_fault_flag_arm_q;
    pin_in_s     s1_q, s2_q;
    logic        sck_d1_q, msck_q;
    st_e         st_q;
    logic [3:0]  half_q, nbit_q;
    logic [10:0] div_q;
    logic [7:0]  rdata_c;
    logic        mapped_c;

    wire system_enable    = main_q[MAIN_SPE];
    wire role_select   = main_q[MAIN_ROLE_SELECT];
    wire clock_polarity   = main_q[MAIN_CLOCK_POLARITY];
    wire clock_phase   = main_q[MAIN_CLOCK_PHASE];
    wire lsbf   = main_q[MAIN_LSBF];
    wire select_output_enable   = main_q[MAIN_SELECT_OUTPUT_ENABLE];
    wire mode_fault_enable = opt_q[OPT_MODE_FAULT_ENABLE];
    wire bidir  = opt_q[OPT_BIDIR];
    wire single_wire_select   = opt_q[OPT_SINGLE_WIRE_SELECT];

    // APB phases
    wire acc     = ce & psel & penable & ~pready;
    wire done_ap = ce & psel & penable & pready;
    wire wr      = done_ap & pwrite;
    wire rd      = done_ap & ~pwrite;
    wire wr_main = wr & (paddr == OFF_MAIN);
    wire wr_data = wr & (paddr == OFF_DATA);
    wire rd_stat = rd & (paddr == OFF_STAT);
    wire rd_data = rd & (paddr == OFF_DATA);

    // Pin synchroniser, second stage only is read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q     <= '1;
            s2_q     <= '1;
            sck_d1_q <= 1'b0;
        end else if (ce) begin
            s1_q     <= pins_in;
            s2_q     <= s1_q;
            sck_d1_q <= s2_q.sck;
        end
    end

    wire run  = ce & ~(wait_mode & opt_q[OPT_SWAI]);
    wire sel  = ~s2_q.ss_n;
    wire lead = (s2_q.sck ^ clock_polarity) & ~(sck_d1_q ^ clock_polarity);
    wire trail = ~(s2_q.sck ^ clock_polarity) & (sck_d1_q ^ clock_polarity);
    wire din  = role_select ? (single_wire_select ? s2_q.mosi : s2_q.miso)
                     : (single_wire_select ? s2_q.miso : s2_q.mosi);
    wire dout = lsbf ? tsh_q[0] : tsh_q[7];
    wire mode_fault_flag_ev = ce & system_enable & role_select & mode_fault_enable & ~select_output_enable & sel;
    wire load = run & system_enable & ~mode_fault_flag_ev & (st_q == ST_IDLE) &
                ((txfull_q & role_select) | (~role_select & sel));
    wire [10:0] hp   = half_period(baud_q);
    wire        tick = (st_q == ST_MASTER) & (div_q == hp - 11'd1);
    wire [4:0]  kk   = {1'b0, half_q} + 5'd1;
    wire m_samp  = tick & kk[0];
    wire m_shift = tick & ~kk[0] & (kk != LAST_HALF);
    wire m_done  = run & tick & (kk == LAST_HALF);
    wire s_act   = (st_q == ST_SLAVE) & sel;
    wire s_samp  = s_act & (clock_phase ? trail : lead);
    wire s_shift = s_act & (clock_phase ? lead & (nbit_q != 4'h0) : trail);
    wire s_done  = run & s_samp & (nbit_q == LAST_BIT);
    wire xdone   = system_enable & ~mode_fault_flag_ev & (m_done | s_done);

    // Serial engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q   <= ST_IDLE;
            half_q <= 4'h0;
            nbit_q <= 4'h0;
            div_q  <= 11'h000;
            msck_q <= 1'b0;
            tsh_q  <= 8'h00;
            rsh_q  <= 8'h00;
        end else if (ce && (!system_enable || mode_fault_flag_ev)) begin
            st_q   <= ST_IDLE;
            half_q <= 4'h0;
            nbit_q <= 4'h0;
            msck_q <= 1'b0;
        end else if (run) begin
            unique case (st_q)
                ST_IDLE: begin
                    half_q <= 4'h0;
                    nbit_q <= 4'h0;
                    div_q  <= 11'h000;
                    msck_q <= 1'b0;
                    if (load) begin
                        if (txfull_q) begin
                            tsh_q <= txbuf_q;
                        end
                        st_q <= role_select ? ST_MASTER : ST_SLAVE;
                        msck_q <= role_select & clock_phase;
                    end
                end
                ST_MASTER: begin
                    div_q <= tick ? 11'h000 : div_q + 11'd1;
                    if (tick) begin
                        half_q <= kk[3:0];
                        if (!clock_phase || kk <= CPHA1_END) begin
                            msck_q <= ~msck_q;
                        end
                        if (m_samp) begin
                            rsh_q <= shift_in(rsh_q, din, lsbf);
                        end
                        if (m_shift) begin
                            tsh_q <= shift_in(tsh_q, 1'b0, lsbf);
                        end
                        if (m_done) begin
                            st_q <= ST_IDLE;
                        end
                    end
                end
                ST_SLAVE: begin
                    if (!sel) begin
                        st_q <= ST_IDLE;
                    end else begin
                        if (s_samp) begin
                            rsh_q  <= shift_in(rsh_q, din, lsbf);
                            nbit_q <= nbit_q + 4'd1;
                        end
                        if (s_shift) begin
                            tsh_q <= shift_in(tsh_q, 1'b0, lsbf);
                        end
                        if (s_done) begin
                            st_q <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_q     <= MAIN_RST;
            opt_q      <= OPT_RST;
            baud_q     <= BAUD_RST;
            irq_mask_q <= MASK_RST;
        end else if (ce) begin
            if (wr_main) begin
                main_q <= pwdata[7:0];
            end
            if (mode_fault_flag_ev) begin
                main_q[MAIN_ROLE_SELECT] <= 1'b0;
            end
            if (wr && paddr == OFF_OPT) begin
                opt_q <= pwdata[7:0] & OPT_IMPL;
            end
            if (wr && paddr == OFF_BAUD) begin
                baud_q <= pwdata[7:0] & BAUD_IMPL;
            end
            if (wr && paddr == OFF_IRQ_MASK) begin
                irq_mask_q <= pwdata[2:0];
            end
        end
    end

    // Data buffers and flags, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxf_q      <= 1'b0;
            txef_q     <= 1'b1;
            txfull_q   <= 1'b0;
            mode_fault_flag_q     <= 1'b0;
            rxf_arm_q  <= 1'b0;
            txef_arm_q <= 1'b0;
            mode_fault_flag_arm_q <= 1'b0;
            txbuf_q    <= 8'h00;
            rxbuf_q    <= 8'h00;
        end else if (ce) begin
            if (!system_enable) begin
                rxf_q      <= 1'b0;
                txef_q     <= 1'b1;
                txfull_q   <= 1'b0;
                rxf_arm_q  <= 1'b0;
                txef_arm_q <= 1'b0;
            end else begin
                if (xdone) begin
                    rxf_q   <= 1'b1;
                    rxbuf_q <= s_done ? shift_in(rsh_q, din, lsbf) : rsh_q;
                end else if (rd_data && rxf_arm_q) begin
                    rxf_q <= 1'b0;
                end
                if (rd_stat) begin
                    rxf_arm_q  <= rxf_q;
                    txef_arm_q <= txef_q;
                end else if (rd_data) begin
                    rxf_arm_q <= 1'b0;
                end
                if (wr_data && txef_arm_q && txef_q) begin
                    txbuf_q    <= pwdata[7:0];
                    txfull_q   <= 1'b1;
                    txef_q     <= 1'b0;
                    txef_arm_q <= 1'b0;
                end else if (load && txfull_q) begin
                    txfull_q <= 1'b0;
                    txef_q   <= 1'b1;
                end
            end
            if (mode_fault_flag_ev) begin
                mode_fault_flag_q <= 1'b1;
            end else if (wr_main && mode_fault_flag_arm_q) begin
                mode_fault_flag_q <= 1'b0;
            end
            if (rd_stat) begin
                mode_fault_flag_arm_q <= mode_fault_flag_q;
            end else if (wr_main) begin
                mode_fault_flag_arm_q <= 1'b0;
            end
        end
    end

    // Sticky interrupt status, write one to clear
    wire [2:0] irq_ev = {txef_q & main_q[MAIN_TIE],
                         mode_fault_flag_q & main_q[MAIN_RFIE],
                         rxf_q & main_q[MAIN_RFIE]};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st_q <= 3'h0;
            irq      <= 1'b0;
        end else if (ce) begin
            irq_st_q <= (irq_st_q & ~((wr && paddr == OFF_IRQ_STAT) ?
                         pwdata[2:0] : 3'h0)) | irq_ev;
            irq      <= |(irq_st_q & irq_mask_q);
        end
    end

    // Register readback
    always_comb begin
        rdata_c  = 8'h00;
        mapped_c = 1'b1;
        unique case (paddr)
            OFF_MAIN:     rdata_c = main_q;
            OFF_OPT:      rdata_c = opt_q;
            OFF_BAUD:     rdata_c = baud_q;
            OFF_STAT:     rdata_c = {rxf_q, 1'b0, txef_q, mode_fault_flag_q, 4'h0};
            OFF_DATA:     rdata_c = rxbuf_q;
            OFF_IRQ_STAT: rdata_c = {5'h00, irq_st_q};
            OFF_IRQ_MASK: rdata_c = {5'h00, irq_mask_q};
            default:      mapped_c = 1'b0;
        endcase
    end

    // APB answer, one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= acc;
            pslverr <= acc & ~mapped_c;
            if (acc) begin
                prdata <= {24'h00_0000, rdata_c};
            end
        end
    end

    // Pin drivers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_out <= '0;
        end else if (ce) begin
            pins_out.sck_o   <= (role_select & msck_q) ^ clock_polarity;
            pins_out.sck_oe  <= system_enable & role_select;
            pins_out.mosi_o  <= dout;
            pins_out.mosi_oe <= system_enable & role_select & (~single_wire_select | bidir);
            pins_out.miso_o  <= dout;
            pins_out.miso_oe <= system_enable & ~role_select & sel & (~single_wire_select | bidir);
            // Select falls with the load so it leads the first clock edge
            pins_out.ss_n_o  <= ~((st_q == ST_MASTER) | (load & role_select));
            pins_out.ss_oe   <= system_enable & role_select & mode_fault_enable & select_output_enable;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !ce);

    sequence s_rx_irq_cause;
        rxf_q && main_q[MAIN_RFIE] && irq_mask_q[IRQ_RX];
    endsequence
    property p_rx_irq;
        s_rx_irq_cause ##1 s_rx_irq_cause |=> irq;
    endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("rx irq missing");

    property p_disable;
        !system_enable |=> txef_q && !rxf_q && st_q == ST_IDLE && !txfull_q;
    endproperty
    a_disable: assert property (p_disable) else $error("disable state");

    sequence s_tx_irq_cause;
        txef_q && main_q[MAIN_TIE] && irq_mask_q[IRQ_TX];
    endsequence
    property p_tx_irq;
        s_tx_irq_cause ##1 s_tx_irq_cause |=> irq;
    endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("tx irq missing");

    property p_role;
        system_enable && !mode_fault_flag_ev && !wr_main ##1 system_enable |-> pins_out.sck_oe == $past(role_select);
    endproperty
    a_role: assert property (p_role) else $error("sck drive role");

    property p_idle_pol;
        st_q == ST_IDLE && !load ##1 st_q == ST_IDLE |=>
            pins_out.sck_o == $past(clock_polarity);
    endproperty
    a_idle_pol: assert property (p_idle_pol) else $error("sck idle");

    property p_phase;
        load && role_select |=> msck_q == $past(clock_phase);
    endproperty
    a_phase: assert property (p_phase) else $error("first edge");

    property p_opt_zero;
        acc && paddr == OFF_OPT |=> prdata[7:5] == 3'h0 && !prdata[2];
    endproperty
    a_opt_zero: assert property (p_opt_zero) else $error("opt bits");

    property p_release;
        !system_enable ##1 !system_enable |-> pins_out == (pins_out & 8'haa);
    endproperty
    a_release: assert property (p_release) else $error("pins held");

    property p_fault;
        mode_fault_flag_ev |=> mode_fault_flag_q && !role_select && st_q == ST_IDLE;
    endproperty
    a_fault: assert property (p_fault) else $error("mode fault");
endmodule : spi_control_config

// ===== spi_slave_model.sv
// Behavioural serial slave at the far end of the link
module spi_slave_model (
    // Link pins
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       sel_n,
    output logic            miso,
    // Format and data
    input  wire logic       clock_polarity,
    input  wire logic       clock_phase,
    input  wire logic       lsbf,
    input  wire logic [7:0] tx_byte,
    output logic      [7:0] rx_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    int nxt;
    int got;

    function automatic logic pick(input logic [7:0] d, input int k);
        return lsbf ? d[k] : d[7-k];
    endfunction : pick

    initial begin
        miso = 1'b1;
        rx_byte = 8'h00;
        nxt = 0;
        got = 0;
    end

    // Phase 0 needs the first bit ready before the first edge
    always @(negedge sel_n) begin
        got = 0;
        nxt = clock_phase ? 0 : 1;
        if (!clock_phase) begin
            miso = pick(tx_byte, 0);
        end
    end

    // Released line shows the inverse of its last value
    always @(posedge sel_n) begin
        miso = ~miso;
    end

    always @(sck) begin
        if (!sel_n) begin
            if (sck == (clock_polarity ^ !clock_phase)) begin
                if (got < 8) begin
                    rx_byte[lsbf ? got : 7 - got] = mosi;
                end
                got++;
            end else if (nxt < 8) begin
                miso = pick(tx_byte, nxt);
                nxt++;
            end
        end
    end
endmodule : spi_slave_model

// ===== tb_spi_control_config.sv
// Self-checking bench for the serial interface control block
module tb_spi_control_config;
    timeunit 1ns;
    timeprecision 1ps;
    import spi_cfg_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  paddr, cur, m_tx, m_rx;
    logic [31:0] pwdata, prdata, r;
    logic        tb_ss_n, sel_w, miso_m, m_clock_polarity, m_clock_phase, m_lsbf;
    logic        wait_m;
    logic [33:0] expq[$];
    logic [33:0] n;
    pin_in_s     pin_i;
    pin_out_s    pin_o;
    int          fail_count, samples_checked;

    assign sel_w = pin_o.ss_oe ? pin_o.ss_n_o : tb_ss_n;
    assign pin_i = {1'b1, pin_o.mosi_oe ? pin_o.mosi_o : 1'b1, miso_m, sel_w};

    spi_control_config dut_u (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .wait_mode(wait_m),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .pins_in(pin_i), .pins_out(pin_o)
    );

    spi_slave_model slave_u (
        .sck(pin_o.sck_o), .mosi(pin_o.mosi_o), .sel_n(sel_w),
        .miso(miso_m), .clock_polarity(m_clock_polarity), .clock_phase(m_clock_phase), .lsbf(m_lsbf),
        .tx_byte(m_tx), .rx_byte(m_rx)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input logic [32:0] g, input logic [32:0] e);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic tally_and_finish();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        apb(1'b1, a, {24'h0, d}, q);
    endtask : wr

    // Expected answer is queued, the monitor compares it when c is set
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic c, output logic [31:0] q);
        expq.push_back({c, a > OFF_IRQ_MASK, e});
        apb(1'b0, a, 32'h0, q);
    endtask : rd

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
        begin
            n = expq.pop_front();
            if (n[33]) begin
                chk({pslverr, prdata}, n[32:0]);
            end
        end
    end

    task automatic xfer(input logic [2:0] m, input logic drain);
        logic [7:0] tx, mt;
        logic [31:0] q;
        int k;
        tx = 8'($urandom);
        mt = 8'($urandom);
        m_tx <= mt;
        {m_lsbf, m_clock_phase, m_clock_polarity} <= m;
        cur[MAIN_SPE] = 1'b0;
        wr(OFF_MAIN, cur);
        cur = 8'h00;
        cur[MAIN_RFIE] = 1'b1;
        cur[MAIN_ROLE_SELECT] = 1'b1;
        cur[MAIN_SELECT_OUTPUT_ENABLE] = 1'b1;
        {cur[MAIN_LSBF], cur[MAIN_CLOCK_PHASE], cur[MAIN_CLOCK_POLARITY]} = m;
        wr(OFF_MAIN, cur);
        cur[MAIN_SPE] = 1'b1;
        wr(OFF_MAIN, cur);
        repeat (4) @(posedge pclk);
        chk(pin_o.sck_o, m[0]);
        rd(OFF_STAT, 32'h20, 1'b1, q);
        wr(OFF_DATA, tx);
        repeat (30) @(posedge pclk);
        chk({pin_o.ss_oe, pin_o.ss_n_o}, 2'b10);
        k = 0;
        do begin
            rd(OFF_STAT, 32'h0, 1'b0, q);
            k++;
        end while (q[STAT_RXF] !== 1'b1 && k < 300);
        chk(q[STAT_RXF], 1'b1);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b1);
        chk(m_rx, tx);
        if (drain) begin
            rd(OFF_DATA, {24'h0, mt}, 1'b1, q);
            wr(OFF_IRQ_STAT, 8'h07);
        end
    endtask : xfer

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {m_clock_polarity, m_clock_phase, m_lsbf, m_tx} = '0;
        presetn = 1'b0;
        tb_ss_n = 1'b1;
        wait_m = 1'b0;
        cur = MAIN_RST;
        fail_count = 0;
        samples_checked = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        void'($urandom(32'hb59407e1));
        rd(OFF_MAIN, {24'h0, MAIN_RST}, 1'b1, r);
        rd(OFF_OPT, {24'h0, OPT_RST}, 1'b1, r);
        rd(OFF_BAUD, {24'h0, BAUD_RST}, 1'b1, r);
        rd(OFF_IRQ_MASK, {29'h0, MASK_RST}, 1'b1, r);
        rd(8'h1c, 32'h0, 1'b1, r);
        wr(OFF_OPT, 8'hff);
        rd(OFF_OPT, 32'h1b, 1'b1, r);
        wr(OFF_OPT, 8'h10);
        wr(OFF_BAUD, 8'h12);
        for (int m = 0; m < 8; m++) begin
            xfer(3'(m), 1'b1);
        end
        wr(OFF_MAIN, 8'h70);
        wr(OFF_IRQ_MASK, 8'h04);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b1);
        wr(OFF_IRQ_MASK, 8'h00);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b0);
        wr(OFF_IRQ_STAT, 8'h07);
        rd(OFF_IRQ_STAT, 32'h4, 1'b1, r);
        cur = 8'h50;
        wr(OFF_MAIN, cur);
        wr(OFF_IRQ_STAT, 8'h07);
        wr(OFF_IRQ_MASK, 8'h07);
        xfer(3'h0, 1'b0);
        cur[MAIN_SPE] = 1'b0;
        wr(OFF_MAIN, cur);
        repeat (3) @(posedge pclk);
        chk({pin_o.sck_oe, pin_o.mosi_oe, pin_o.miso_oe, pin_o.ss_oe}, 0);
        rd(OFF_STAT, 32'h20, 1'b1, r);
        wr(OFF_MAIN, 8'h40);
        rd(OFF_STAT, 32'h20, 1'b1, r);
        wr(OFF_DATA, 8'h5a);
        repeat (20) @(posedge pclk);
        chk(pin_o.sck_oe, 1'b0);
        wr(OFF_OPT, 8'h11);
        wr(OFF_MAIN, 8'h52);
        repeat (4) @(posedge pclk);
        chk(pin_o.mosi_oe, 1'b0);
        wr(OFF_OPT, 8'h19);
        repeat (4) @(posedge pclk);
        chk({pin_o.mosi_oe, pin_o.miso_oe}, 2'b10);
        wr(OFF_OPT, 8'h10);
        wr(OFF_MAIN, 8'hd0);
        tb_ss_n <= 1'b0;
        repeat (8) @(posedge pclk);
        rd(OFF_STAT, 32'h30, 1'b1, r);
        rd(OFF_MAIN, 32'hc0, 1'b1, r);
        chk(irq, 1'b1);
        tb_ss_n <= 1'b1;
        // Wait with clock stop set holds the engine idle
        wr(OFF_OPT, 8'h12);
        wait_m <= 1'b1;
        wr(OFF_MAIN, 8'h52);
        rd(OFF_STAT, 32'h20, 1'b1, r);
        wr(OFF_DATA, 8'ha5);
        repeat (20) @(posedge pclk);
        chk(pin_o.ss_n_o, 1'b1);
        wait_m <= 1'b0;
        repeat (20) @(posedge pclk);
        chk(pin_o.ss_n_o, 1'b0);
        tally_and_finish();
    end

    initial begin
        repeat (60000) @(posedge pclk);
        fail_count++;
        tally_and_finish();
    end
endmodule : tb_spi_control_config
